/* verilog/asq_pkg.sv */
// Shared constants of the sample sequencer: register map, control fields,
// reset values, cycle counts and channel numbering.
// Assumes the 100 MHz REF_CLK domain and a 4-bit register address.
package asq_pkg;

   // ****************************************************************
   // Register addresses on the 4-bit parallel port
   // ****************************************************************
   localparam logic [3:0] ADDR_SEQUENCE_CONTROL = 4'h0;
   localparam logic [3:0] ADDR_STATUS_FLAGS = 4'h1;
   localparam logic [3:0] ADDR_RESULT_PHASE_U = 4'h2;
   localparam logic [3:0] ADDR_RESULT_PHASE_V = 4'h3;
   localparam logic [3:0] ADDR_RESULT_PHASE_W = 4'h4;
   localparam logic [3:0] ADDR_RESULT_SPARE = 4'h5;

   // ****************************************************************
   // Control and status fields
   // ****************************************************************
   localparam int CTRL_SPARE_EN_BIT = 2;
   localparam int CTRL_THREE_PHASE_BIT = 3;
   localparam int CTRL_IRQ_EN_BIT = 7;
   localparam int STAT_CONV_DONE_BIT = 0;
   localparam logic [11:0] CTRL_RESET = 12'h000;
   localparam logic [11:0] STAT_RESET = 12'h000;
   localparam logic [11:0] RESULT_RESET = 12'h000;

   // ****************************************************************
   // Cycle counts
   // ****************************************************************
   localparam int CNT_W = 6;
   localparam logic [5:0] ACQ_CYCLES = 6'h14;
   localparam logic [5:0] CONV_CYCLES = 6'h28;
   localparam logic [5:0] REACQ_CYCLES = 6'h14;

   // ****************************************************************
   // Channel numbering and groups
   // ****************************************************************
   localparam int NUM_CH = 4;
   localparam logic [1:0] CH_U = 2'h0;
   localparam logic [1:0] CH_V = 2'h1;
   localparam logic [1:0] CH_W = 2'h2;
   localparam logic [1:0] CH_SPARE = 2'h3;
   localparam logic [3:0] MASK_TWO_PHASE = 4'h6;
   localparam logic [3:0] MASK_THREE_PHASE = 4'h7;
   localparam logic [3:0] MASK_SPARE = 4'h8;

   // Sequencer states, one-hot
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_ACQ = 4'b0010,
      ST_CONV = 4'b0100,
      ST_REACQ = 4'b1000
   } asq_state_t;

endpackage : asq_pkg

/* verilog/asq_timer.sv */
// Down counter that times the acquisition, conversion and reacquisition phases.
// Assumes a synchronous active-low reset and a clock enable from the top.
`timescale 1ns/1ps
module asq_timer #(
   parameter int W = 6,
   parameter logic [5:0] RST_VAL = 6'h00
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic en,
   input wire logic load,
   input wire logic [W-1:0] load_val,
   output logic expired
);

   logic [W-1:0] cnt_q;

   // Load on request, otherwise count down to zero and stay there
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cnt_q <= RST_VAL[W-1:0];
      end else if (en) begin
         if (load) begin
            cnt_q <= load_val;
         end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
         end
      end
   end

   // Zero marks the last cycle of the timed phase
   assign expired = (cnt_q == '0);

endmodule : asq_timer

/* verilog/asq_chan_pick.sv */
// Picks the first and the following channel of a conversion group.
// Assumes the group mask holds at least two set bits.
`timescale 1ns/1ps
module asq_chan_pick #(
   parameter int NCH = 4,
   parameter int CW = 2
) (
   input wire logic [NCH-1:0] mask,
   input wire logic [CW-1:0] cur,
   output logic [CW-1:0] first,
   output logic [CW-1:0] nxt,
   output logic last
);

   logic [NCH-1:0] above;

   // Channels of the group that come after the current one
   for (genvar gi = 0; gi < NCH; gi++) begin : g_above
      assign above[gi] = mask[gi] && (CW'(gi) > cur);
   end

   // Lowest channel wins, so the group runs in ascending order
   always_comb begin
      first = '0;
      nxt = '0;
      for (int i = NCH - 1; i >= 0; i--) begin
         if (mask[i]) begin
            first = CW'(i);
         end
         if (above[i]) begin
            nxt = CW'(i);
         end
      end
   end

   assign last = ~|above;

endmodule : asq_chan_pick

/* verilog/asq_sequencer.sv */
// Sample sequencer for a four-channel simultaneous sample-and-hold and one
// successive-approximation converter, with its parallel register port.
// Assumes all pins synchronous to REF_CLK; the analog core converts the
// channel on CONV_CHAN after CONV_START and holds ADC_CODE valid by the
// last cycle of that channel's slot.
//
// Behaviour
// RULE_01: Acquisition lasts 20 clock cycles whatever the channel selection.
// RULE_02: Each selected channel takes 40 cycles of conversion.
// RULE_03: All four inputs held together, selected ones converted one by one.
// RULE_04: A group always holds two channels or more.
// RULE_05: A rising trigger pin held one cycle starts a group.
// RULE_06: Software writes zero into control bits 0 and 1.
// RULE_07: After reset only phase V and W are converted.
// RULE_08: Control bit 3 selects U, V, W and optionally spare channel.
// RULE_09: Result registers read independently, any order, without side effects.
// RULE_10: With control bit 7 set, each finished group raises an interrupt.
// RULE_11: Status bit 0 marks the converter as interrupt source.
// RULE_12: Reading the status register clears its flags.
// RULE_13: Eleven-bit result stored left justified, low bit zero.
// RULE_14: Each channel has its own result register.
// RULE_15: Host holds reset low at least two cycles after power-up.
// RULE_16: Host waits 20 cycles after reset before the first trigger.
// RULE_17: Hold is entered on a falling clock edge.
// RULE_18: At least 20 reacquisition cycles follow each group.
// RULE_19: An early trigger is kept and served after reacquisition.
// RULE_20: Interrupt pin is open drain, only ever pulled low.
// RULE_21: Host may time completion itself instead of using interrupts.
// RULE_22: Host writes last one clock cycle, no wait states.
// RULE_23: Interrupt stays low while an enabled flag is set.
`timescale 1ns/1ps
module asq_sequencer (
   input wire logic REF_CLK,
   input wire logic RSTN,
   input wire logic CLK_EN,
   input wire logic CS_N,
   input wire logic RD_N,
   input wire logic WR_N,
   input wire logic [3:0] ADDR,
   input wire logic [11:0] DATA_IN,
   output logic [11:0] DATA_OUT,
   output logic DATA_OE,
   input wire logic CONVERSION_TRIGGER,
   output logic IRQ_N_OUT,
   output logic IRQ_N_OE,
   output logic SHA_HOLD,
   output logic CONV_START,
   output logic [1:0] CONV_CHAN,
   input wire logic [10:0] ADC_CODE
);

   // ****************************************************************
   // Declarations
   // ****************************************************************
   asq_pkg::asq_state_t state_q;
   asq_pkg::asq_state_t state_d;
   logic [11:0] ctrl_q;
   logic [11:0] stat_q;
   logic [11:0] result_q [asq_pkg::NUM_CH];
   logic [11:0] rd_mux;
   logic [11:0] data_out_q;
   logic data_oe_q;
   logic rd_prev_q;
   logic trig_prev_q;
   logic trig_pend_q;
   logic irq_oe_q;
   logic irq_out_q;
   logic hold_q;
   logic start_q;
   logic [1:0] chan_q;
   logic [3:0] grp_mask_q;
   logic [3:0] sel_mask;
   logic rd_act;
   logic rd_start;
   logic wr_act;
   logic stat_rd;
   logic trig_edge;
   logic trig_seen;
   logic tmr_expired;
   logic tmr_load;
   logic [5:0] tmr_val;
   logic [1:0] first_chan;
   logic [1:0] next_chan;
   logic last_chan;
   logic chan_end;
   logic grp_end;
   logic grp_go;

   // ****************************************************************
   // Register port decode
   // ****************************************************************

   // Strobes of the parallel port, one cycle per host write
   assign rd_act = !CS_N && !RD_N;
   assign rd_start = rd_act && !rd_prev_q;
   assign wr_act = !CS_N && !WR_N && RD_N; // RULE_22
   assign stat_rd = rd_start && (ADDR == asq_pkg::ADDR_STATUS_FLAGS);

   // Read data select; unmapped addresses read zero
   always_comb begin
      unique case (ADDR)
         asq_pkg::ADDR_SEQUENCE_CONTROL: rd_mux = ctrl_q;
         asq_pkg::ADDR_STATUS_FLAGS: rd_mux = stat_q;
         asq_pkg::ADDR_RESULT_PHASE_U: rd_mux = result_q[asq_pkg::CH_U]; // RULE_09
         asq_pkg::ADDR_RESULT_PHASE_V: rd_mux = result_q[asq_pkg::CH_V];
         asq_pkg::ADDR_RESULT_PHASE_W: rd_mux = result_q[asq_pkg::CH_W];
         asq_pkg::ADDR_RESULT_SPARE: rd_mux = result_q[asq_pkg::CH_SPARE];
         default: rd_mux = 12'h000;
      endcase
   end

   // Read data is captured once at the start of a read strobe
   always_ff @(posedge REF_CLK) begin
      if (!RSTN) begin
         data_out_q <= 12'h000;
         data_oe_q <= 1'b0;
         rd_prev_q <= 1'b0;
      end else if (CLK_EN) begin
         rd_prev_q <= rd_act;
         data_oe_q <= rd_act;
         if (rd_start) begin
            data_out_q <= rd_mux;
         end
      end
   end

   // ****************************************************************
   // Control and status registers
   // ****************************************************************

   // Control register; bits 0 and 1 are stored but steer nothing
   always_ff @(posedge REF_CLK) begin
      if (!RSTN) begin
         ctrl_q <= asq_pkg::CTRL_RESET; // RULE_07
      end else if (CLK_EN) begin
         if (wr_act && (ADDR == asq_pkg::ADDR_SEQUENCE_CONTROL)) begin
            ctrl_q <= DATA_IN; // RULE_06
         end
      end
   end

   // Done flag: a group end in the clearing cycle wins over the clear
   always_ff @(posedge REF_CLK) begin
      if (!RSTN) begin
         stat_q <= asq_pkg::STAT_RESET;
      end else if (CLK_EN) begin
         if (grp_end) begin
            stat_q[asq_pkg::STAT_CONV_DONE_BIT] <= 1'b1; // RULE_11
         end else if (stat_rd) begin
            stat_q <= 12'h000; // RULE_12
         end
      end
   end

   // Open-drain request: pin pulled low only while an enabled flag stands
   always_ff @(posedge REF_CLK) begin
      if (!RSTN) begin
         irq_oe_q <= 1'b0;
         irq_out_q <= 1'b0;
      end else if (CLK_EN) begin
         irq_out_q <= 1'b0; // RULE_20
         irq_oe_q <= ctrl_q[asq_pkg::CTRL_IRQ_EN_BIT] &&
                     stat_q[asq_pkg::STAT_CONV_DONE_BIT]; // RULE_10 RULE_23
      end
   end

   // ****************************************************************
   // Trigger capture
   // ****************************************************************

   // A rising trigger is held pending until a group may start
   assign trig_edge = CONVERSION_TRIGGER && !trig_prev_q; // RULE_05
   assign trig_seen = trig_edge || trig_pend_q;

   always_ff @(posedge REF_CLK) begin
      if (!RSTN) begin
         trig_prev_q <= 1'b0;
         trig_pend_q <= 1'b0;
      end else if (CLK_EN) begin
         trig_prev_q <= CONVERSION_TRIGGER;
         if (grp_go) begin
            trig_pend_q <= 1'b0;
         end else if (trig_edge) begin
            trig_pend_q <= 1'b1; // RULE_19
         end
      end
   end

   // ****************************************************************
   // Channel selection
   // ****************************************************************

   // Group mask from the mode bits; never fewer than two channels
   always_comb begin
      if (ctrl_q[asq_pkg::CTRL_THREE_PHASE_BIT]) begin
         sel_mask = asq_pkg::MASK_THREE_PHASE; // RULE_08
      end else begin
         sel_mask = asq_pkg::MASK_TWO_PHASE; // RULE_07 RULE_04
      end
      if (ctrl_q[asq_pkg::CTRL_SPARE_EN_BIT]) begin
         sel_mask = sel_mask | asq_pkg::MASK_SPARE;
      end
   end

   asq_chan_pick #(
      .NCH(asq_pkg::NUM_CH),
      .CW(2)
   ) u_pick (
      .mask(grp_mask_q),
      .cur(chan_q),
      .first(first_chan),
      .nxt(next_chan),
      .last(last_chan)
   );

   // ****************************************************************
   // Sequencer
   // ****************************************************************

   assign grp_go = (state_d == asq_pkg::ST_ACQ) && (state_q != asq_pkg::ST_ACQ);
   assign chan_end = (state_q == asq_pkg::ST_CONV) && tmr_expired;
   assign grp_end = chan_end && last_chan;

   // Phase timer; reset starts in reacquisition so the input settles first
   asq_timer #(
      .W(asq_pkg::CNT_W),
      .RST_VAL(asq_pkg::REACQ_CYCLES - 6'h01)
   ) u_timer (
      .clk(REF_CLK),
      .rst_n(RSTN),
      .en(CLK_EN),
      .load(tmr_load),
      .load_val(tmr_val),
      .expired(tmr_expired)
   );

   // Next state and the timer load that goes with each phase change
   always_comb begin
      state_d = state_q;
      tmr_load = 1'b0;
      tmr_val = asq_pkg::ACQ_CYCLES - 6'h01;
      unique case (state_q)
         asq_pkg::ST_IDLE: begin
            if (trig_seen) begin
               state_d = asq_pkg::ST_ACQ;
               tmr_load = 1'b1; // RULE_01
            end
         end
         asq_pkg::ST_ACQ: begin
            if (tmr_expired) begin
               state_d = asq_pkg::ST_CONV;
               tmr_load = 1'b1;
               tmr_val = asq_pkg::CONV_CYCLES - 6'h01; // RULE_02
            end
         end
         asq_pkg::ST_CONV: begin
            if (tmr_expired) begin
               tmr_load = 1'b1;
               if (last_chan) begin
                  state_d = asq_pkg::ST_REACQ;
                  tmr_val = asq_pkg::REACQ_CYCLES - 6'h01; // RULE_18
               end else begin
                  tmr_val = asq_pkg::CONV_CYCLES - 6'h01; // RULE_02
               end
            end
         end
         asq_pkg::ST_REACQ: begin
            if (tmr_expired) begin
               if (trig_seen) begin
                  state_d = asq_pkg::ST_ACQ; // RULE_19
                  tmr_load = 1'b1;
               end else begin
                  state_d = asq_pkg::ST_IDLE;
               end
            end
         end
      endcase
   end

   // State, group mask and current channel
   always_ff @(posedge REF_CLK) begin
      if (!RSTN) begin
         state_q <= asq_pkg::ST_REACQ; // RULE_16
         grp_mask_q <= asq_pkg::MASK_TWO_PHASE;
         chan_q <= asq_pkg::CH_V;
         start_q <= 1'b0;
      end else if (CLK_EN) begin
         state_q <= state_d;
         start_q <= 1'b0;
         if (grp_go) begin
            grp_mask_q <= sel_mask;
         end
         if ((state_q == asq_pkg::ST_ACQ) && tmr_expired) begin
            chan_q <= first_chan; // RULE_03
            start_q <= 1'b1;
         end else if (chan_end && !last_chan) begin
            chan_q <= next_chan; // RULE_03
            start_q <= 1'b1;
         end
      end
   end

   // Results land in their own register, left justified
   for (genvar gc = 0; gc < asq_pkg::NUM_CH; gc++) begin : g_result
      always_ff @(posedge REF_CLK) begin
         if (!RSTN) begin
            result_q[gc] <= asq_pkg::RESULT_RESET;
         end else if (CLK_EN) begin
            if (chan_end && (chan_q == 2'(gc))) begin
               result_q[gc] <= {ADC_CODE, 1'b0}; // RULE_13 RULE_14
            end
         end
      end
   end

   // Hold switches on the falling edge, all four inputs at once
   always_ff @(negedge REF_CLK) begin
      if (!RSTN) begin
         hold_q <= 1'b0;
      end else if (CLK_EN) begin
         hold_q <= (state_q == asq_pkg::ST_CONV); // RULE_17 RULE_03
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign DATA_OUT = data_out_q;
   assign DATA_OE = data_oe_q;
   assign IRQ_N_OUT = irq_out_q;
   assign IRQ_N_OE = irq_oe_q;
   assign SHA_HOLD = hold_q;
   assign CONV_START = start_q;
   assign CONV_CHAN = chan_q;

endmodule : asq_sequencer

/* test/asq_checker.sv */
// Checker: port assertions for the sample sequencer.
// Assumes CLK_EN is held high and is bound to asq_sequencer.
`timescale 1ns/1ps
module asq_checker (
   input wire logic REF_CLK,
   input wire logic RSTN,
   input wire logic CS_N,
   input wire logic RD_N,
   input wire logic WR_N,
   input wire logic [3:0] ADDR,
   input wire logic [11:0] DATA_OUT,
   input wire logic DATA_OE,
   input wire logic IRQ_N_OUT,
   input wire logic IRQ_N_OE,
   input wire logic SHA_HOLD,
   input wire logic CONV_START,
   input wire logic [1:0] CONV_CHAN
);
   // ****
   // Helper logic
   // ****
   logic rd_q;
   logic wr_q;
   logic rs_q;
   logic rd_start;
   logic [6:0] gap_q;
   logic [6:0] low_q;
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (!RSTN);
   // First cycle of a read strobe
   assign rd_start = !CS_N && !RD_N && !rd_q;
   // Strobe history
   always_ff @(posedge REF_CLK) begin
      rd_q <= !CS_N && !RD_N;
      wr_q <= !CS_N && !WR_N;
      rs_q <= rd_start;
   end
   // Cycles since the last slot start
   always_ff @(posedge REF_CLK) begin
      if (!RSTN) gap_q <= 7'h7F;
      else if (CONV_START) gap_q <= 7'h01;
      else if (gap_q != 7'h7F) gap_q <= gap_q + 7'h01;
   end
   // Cycles spent tracking
   always_ff @(posedge REF_CLK) begin
      if (!RSTN || SHA_HOLD) low_q <= 7'h00;
      else if (low_q != 7'h7F) low_q <= low_q + 7'h01;
   end
   sequence s_group_start;
      CONV_START && gap_q != 7'h28;
   endsequence
   sequence s_next_slot;
      CONV_START && gap_q == 7'h28;
   endsequence
   // ****
   // Assertions
   // ****
   AST_IRQ_PIN: assert property (IRQ_N_OUT == 1'b0)
      else $error("irq pin data not low");
   AST_IRQ_HOLD: assert property (
      IRQ_N_OE && !rd_start && !rs_q && !wr_q && WR_N |=> IRQ_N_OE)
      else $error("irq released without status read");
   AST_IRQ_SOURCE: assert property (
      rd_start && ADDR == asq_pkg::ADDR_STATUS_FLAGS && IRQ_N_OE |=> DATA_OUT[0])
      else $error("status bit 0 clear while irq pending");
   AST_READ_ANSWER: assert property (rd_start |=> DATA_OE)
      else $error("no read answer");
   AST_UNMAPPED: assert property (
      rd_start && ADDR > asq_pkg::ADDR_RESULT_SPARE |=> DATA_OUT == 12'h000)
      else $error("unmapped read not zero");
   AST_RESULT_LSB: assert property (
      rd_start && ADDR >= asq_pkg::ADDR_RESULT_PHASE_U && ADDR <= asq_pkg::ADDR_RESULT_SPARE
      |=> !DATA_OUT[0])
      else $error("result low bit set");
   AST_SLOT_GAP: assert property (CONV_START |-> gap_q == 7'h28 || gap_q >= 7'h50)
      else $error("slot spacing wrong");
   AST_GROUP_MIN: assert property (s_group_start |-> ##40 CONV_START)
      else $error("group of one channel");
   AST_CHAN_ASCEND: assert property (s_next_slot |-> CONV_CHAN > $past(CONV_CHAN))
      else $error("channel order wrong");
   AST_FIRST_CHAN: assert property (s_group_start |-> CONV_CHAN <= asq_pkg::CH_V)
      else $error("group starts on wrong channel");
   AST_HOLD_START: assert property (
      $rose(SHA_HOLD) |-> CONV_START && low_q >= 7'h27)
      else $error("hold entered early");
endmodule : asq_checker

bind asq_sequencer asq_checker i_chk (.REF_CLK(REF_CLK), .RSTN(RSTN), .CS_N(CS_N),
   .RD_N(RD_N), .WR_N(WR_N), .ADDR(ADDR), .DATA_OUT(DATA_OUT), .DATA_OE(DATA_OE),
   .IRQ_N_OUT(IRQ_N_OUT), .IRQ_N_OE(IRQ_N_OE), .SHA_HOLD(SHA_HOLD),
   .CONV_START(CONV_START), .CONV_CHAN(CONV_CHAN));

/* test/asq_core_model.sv */
// Model of the analog core: a code per converted channel.
// Assumes the code is taken in the last cycle of each 40-cycle slot.
`timescale 1ns/1ps
module asq_core_model (
   input wire logic clk,
   input wire logic conv_start,
   input wire logic [1:0] conv_chan,
   input wire logic [10:0] bias,
   output logic [10:0] adc_code
);
   logic [5:0] cnt_q = 6'h00;
   logic junk_q = 1'b0;
   // Position inside the slot
   always @(posedge clk) begin
      if (conv_start) cnt_q <= 6'h01;
      else if (cnt_q == 6'h29) cnt_q <= 6'h00;
      else if (cnt_q != 6'h00) cnt_q <= cnt_q + 6'h01;
   end
   // Changing pattern while no code is valid
   always @(posedge clk) begin
      junk_q <= ~junk_q;
   end
   // Code settles in the second half of the slot
   assign adc_code = (cnt_q >= 6'h14) ? bias + {9'h000, conv_chan} : {11{junk_q}};
endmodule : asq_core_model

/* test/test_adc_sample_sequencer.sv */
// Bench: register tasks and conversion groups with expected values.
// Assumes the core model on ADC_CODE and the bound checker.
`timescale 1ns/1ps
module test_adc_sample_sequencer;
   logic ref_clk = 1'b0;
   logic rstn = 1'b0;
   logic cs_n = 1'b1;
   logic rd_n = 1'b1;
   logic wr_n = 1'b1;
   logic [3:0] addr = 4'h0;
   logic [11:0] data_in = 12'h000;
   logic trig = 1'b0;
   logic [10:0] bias = 11'h000;
   logic [11:0] data_out;
   logic data_oe;
   logic irq_n_out;
   logic irq_n_oe;
   logic sha_hold;
   logic conv_start;
   logic [1:0] conv_chan;
   logic [10:0] adc_code;
   int mismatches = 0;
   int checked = 0;
   int cyc = 0;
   int mark;
   int done;
   asq_sequencer i_dut (.REF_CLK(ref_clk), .RSTN(rstn), .CLK_EN(1'b1), .CS_N(cs_n),
      .RD_N(rd_n), .WR_N(wr_n), .ADDR(addr), .DATA_IN(data_in), .DATA_OUT(data_out),
      .DATA_OE(data_oe), .CONVERSION_TRIGGER(trig), .IRQ_N_OUT(irq_n_out),
      .IRQ_N_OE(irq_n_oe), .SHA_HOLD(sha_hold), .CONV_START(conv_start),
      .CONV_CHAN(conv_chan), .ADC_CODE(adc_code));
   asq_core_model i_core (.clk(ref_clk), .conv_start(conv_start), .conv_chan(conv_chan),
      .bias(bias), .adc_code(adc_code));
   // Clock and cycle count with hang limit
   always #5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         mismatches++;
         complete_run();
      end
   end
   // ****
   // Tasks
   // ****
   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : complete_run
   task automatic chk(input string name, input logic [11:0] e, input logic [11:0] g);
      checked++;
      if (g !== e) begin
         mismatches++;
         $display("Error %s expected %h seen %h", name, e, g);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [11:0] d);
      @(negedge ref_clk);
      cs_n = 1'b0;
      wr_n = 1'b0;
      addr = a;
      data_in = d;
      @(negedge ref_clk);
      cs_n = 1'b1;
      wr_n = 1'b1;
   endtask : wr
   task automatic rc(input logic [3:0] a, input logic [11:0] e);
      @(negedge ref_clk);
      cs_n = 1'b0;
      rd_n = 1'b0;
      addr = a;
      @(posedge ref_clk);
      @(posedge ref_clk);
      #1;
      chk("data_oe", 12'h001, {11'h000, data_oe});
      chk($sformatf("register %h", a), e, data_out);
      @(negedge ref_clk);
      cs_n = 1'b1;
      rd_n = 1'b1;
   endtask : rc
   task automatic pulse();
      @(negedge ref_clk);
      trig = 1'b1;
      @(posedge ref_clk);
      #1;
      mark = cyc;
      @(negedge ref_clk);
      trig = 1'b0;
   endtask : pulse
   // Follows one group: channel order, start delay, hold edge, completion
   task automatic group(input logic [3:0] mask, input logic irq, input int acq);
      int t;
      int first;
      first = 1;
      for (int ch = 0; ch < 4; ch++) begin
         if (mask[ch]) begin
            t = 0;
            @(posedge ref_clk);
            #1;
            while (conv_start !== 1'b1 && t < 200) begin
               @(posedge ref_clk);
               #1;
               t++;
            end
            chk("channel", 12'(ch), {10'h000, conv_chan});
            if (first == 1) begin
               chk("start delay", 12'(acq), 12'(cyc - mark));
               chk("hold early", 12'h000, {11'h000, sha_hold});
               @(negedge ref_clk);
               #1;
               chk("hold", 12'h001, {11'h000, sha_hold});
               first = 0;
            end
         end
      end
      repeat (40) @(posedge ref_clk);
      #1;
      chk("irq early", 12'h000, {11'h000, irq_n_oe});
      @(posedge ref_clk);
      #1;
      chk("irq", {11'h000, irq}, {11'h000, irq_n_oe});
      done = cyc;
   endtask : group
   // ****
   // Main sequence
   // ****
   initial begin
      repeat (20) @(posedge ref_clk);
      @(negedge ref_clk);
      rstn = 1'b1;
      rc(asq_pkg::ADDR_SEQUENCE_CONTROL, asq_pkg::CTRL_RESET);
      rc(asq_pkg::ADDR_STATUS_FLAGS, asq_pkg::STAT_RESET);
      rc(asq_pkg::ADDR_RESULT_PHASE_U, asq_pkg::RESULT_RESET);
      wr(4'h6, 12'hFFC);
      wr(asq_pkg::ADDR_STATUS_FLAGS, 12'h001);
      rc(4'h6, 12'h000);
      rc(asq_pkg::ADDR_STATUS_FLAGS, 12'h000);
      wr(asq_pkg::ADDR_SEQUENCE_CONTROL, 12'h080);
      bias = 11'h400;
      pulse();
      group(asq_pkg::MASK_TWO_PHASE, 1'b1, 20);
      // Next group requested during reacquisition
      wr(asq_pkg::ADDR_SEQUENCE_CONTROL, 12'h08C);
      bias = 11'h7FC;
      pulse();
      mark = done;
      rc(asq_pkg::ADDR_RESULT_PHASE_W, 12'h804);
      rc(asq_pkg::ADDR_RESULT_PHASE_V, 12'h802);
      rc(asq_pkg::ADDR_RESULT_PHASE_U, 12'h000);
      rc(asq_pkg::ADDR_STATUS_FLAGS, 12'h001);
      rc(asq_pkg::ADDR_STATUS_FLAGS, 12'h000);
      group(4'hF, 1'b1, 39);
      rc(asq_pkg::ADDR_RESULT_PHASE_U, 12'hFF8);
      rc(asq_pkg::ADDR_RESULT_SPARE, 12'hFFE);
      rc(asq_pkg::ADDR_RESULT_PHASE_W, 12'hFFC);
      rc(asq_pkg::ADDR_RESULT_PHASE_V, 12'hFFA);
      rc(asq_pkg::ADDR_STATUS_FLAGS, 12'h001);
      @(posedge ref_clk);
      #1;
      chk("irq cleared", 12'h000, {11'h000, irq_n_oe});
      // Group without interrupt, completion timed by the bench
      wr(asq_pkg::ADDR_SEQUENCE_CONTROL, 12'h008);
      repeat (25) @(posedge ref_clk);
      bias = 11'h010;
      pulse();
      group(asq_pkg::MASK_THREE_PHASE, 1'b0, 20);
      wr(asq_pkg::ADDR_SEQUENCE_CONTROL, 12'h088);
      repeat (2) @(posedge ref_clk);
      #1;
      chk("irq enabled", 12'h001, {11'h000, irq_n_oe});
      rc(asq_pkg::ADDR_SEQUENCE_CONTROL, 12'h088);
      rc(asq_pkg::ADDR_STATUS_FLAGS, 12'h001);
      rc(asq_pkg::ADDR_STATUS_FLAGS, 12'h000);
      rc(asq_pkg::ADDR_RESULT_PHASE_U, 12'h020);
      rc(asq_pkg::ADDR_RESULT_PHASE_W, 12'h024);
      rc(asq_pkg::ADDR_RESULT_SPARE, 12'hFFE);
      // A trigger taken from idle must not leave a second group pending
      repeat (40) @(posedge ref_clk);
      #1;
      chk("no extra group", 12'h000, {11'h000, sha_hold});
      complete_run();
   end
endmodule : test_adc_sample_sequencer
